// ===== inc/obc_pkg.sv
// option byte decoder package: field positions, defaults, encodings
// assumes an 8-bit nonvolatile word per option byte
package obc_pkg;
   // option byte 0 layout
   localparam int OB0_WAKE_BIT   = 7;
   localparam int OB0_RANGE_LSB  = 4;
   localparam int OB0_BOOT_LSB   = 2;
   localparam int OB0_RDP_BIT    = 1;
   localparam int OB0_WRP_BIT    = 0;
   // option byte 1 layout
   localparam int OB1_STARTUP_LSB = 6;
   // erased / default contents
   localparam logic [7:0] OB0_DEFAULT = 8'hFC;
   localparam logic [7:0] OB1_DEFAULT = 8'h3F;
   localparam logic [7:0] OB_ERASED   = 8'hFF;
   // register offsets on the command port
   localparam logic [1:0] ADDR_OB0    = 2'h0;
   localparam logic [1:0] ADDR_OB1    = 2'h1;
   localparam logic [1:0] ADDR_STATUS = 2'h2;
   localparam logic [1:0] ADDR_CMD    = 2'h3;
   // command codes written to ADDR_CMD
   localparam logic [7:0] CMD_ERASE_OPT = 8'hE5;
   localparam logic [7:0] CMD_ERASE_MEM = 8'hA5;
   // oscillator range codes
   localparam logic [2:0] RANGE_LOW_POWER    = 3'h0;
   localparam logic [2:0] RANGE_MEDIUM_POWER = 3'h1;
   localparam logic [2:0] RANGE_MEDIUM_SPEED = 3'h2;
   localparam logic [2:0] RANGE_HIGH_SPEED   = 3'h3;
   localparam logic [2:0] RANGE_VERY_LOW     = 3'h4;
   // startup clock codes
   localparam logic [1:0] START_INT_RC  = 2'h0;
   localparam logic [1:0] START_WAKE_RC = 2'h1;
   localparam logic [1:0] START_XTAL    = 2'h2;
   localparam logic [1:0] START_EXT_CLK = 2'h3;
   // boot block size in bytes per code
   localparam logic [12:0] BOOT_SIZE_0 = 13'h0200;
   localparam logic [12:0] BOOT_SIZE_1 = 13'h0400;
   localparam logic [12:0] BOOT_SIZE_2 = 13'h0800;
   localparam logic [12:0] BOOT_SIZE_3 = 13'h1000;
   typedef enum logic [1:0] {
      OBC_IDLE,
      OBC_MASS_ERASE,
      OBC_OPT_ERASE
   } obc_phase_e;
endpackage

// ===== rtl/obc_decode.sv
// option byte decoder: latches and decodes the two configuration bytes
// assumes the nonvolatile array and flash eraser sit outside; one clock
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module obc_decode
   import obc_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   input  wire logic [7:0]  nv_ob0_i,
   input  wire logic [7:0]  nv_ob1_i,
   input  wire logic        prog_mode_i,
   input  wire logic        mass_erase_done_i,
   input  wire logic [1:0]  addr_i,
   input  wire logic [7:0]  wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [7:0]  rdata_o,
   output logic      [7:0]  nv_wdata_o,
   output logic             nv_wr_ob0_o,
   output logic             nv_wr_ob1_o,
   output logic             mass_erase_o,
   output logic             wakeup_clock_select_o,
   output logic             wake_src_vlp_o,
   output logic      [2:0]  osc_range_a_o,
   output logic             osc_range_valid_o,
   output logic      [1:0]  startup_clock_select_o,
   output logic      [1:0]  boot_block_size_o,
   output logic      [12:0] boot_block_bytes_o,
   output logic             readout_protect_o,
   output logic             write_protect_o,
   output logic             flash_write_allow_o,
   output logic             code_read_allow_o,
   output logic             refused_o
);
   // programming mode is a pin: three flops, change accepted when last two agree
   typedef struct packed {
      logic [2:0]  pm_sync;
      logic        pm;
      logic        latched;
      logic [7:0]  ob0;
      logic [7:0]  ob1;
      obc_phase_e  phase;
      logic [7:0]  rdata;
      logic [7:0]  nv_wdata;
      logic        nv_wr0;
      logic        nv_wr1;
      logic        mass_erase;
      logic        refused;
      logic        wake_vlp;
      logic [2:0]  range;
      logic        range_valid;
      logic [12:0] boot_bytes;
      logic        flash_wr_ok;
      logic        code_rd_ok;
   } obc_state_s;

   obc_state_s st;
   obc_state_s next_st;

   always_comb begin
      logic       pm_agree;
      logic       ob_addr;
      logic       cmd_opt_erase;
      logic       cmd_mem_erase;
      logic       rdp_on;
      logic       wrp_on;
      logic       ext_clock;
      logic [2:0] range_field;
      logic [1:0] boot_code;
      logic [7:0] status_word;
      pm_agree      = (st.pm_sync[2] == st.pm_sync[1]);
      ob_addr       = (addr_i == ADDR_OB0) || (addr_i == ADDR_OB1);
      cmd_opt_erase = (addr_i == ADDR_CMD) && (wdata_i == CMD_ERASE_OPT);
      cmd_mem_erase = (addr_i == ADDR_CMD) && (wdata_i == CMD_ERASE_MEM);
      rdp_on        = st.ob0[OB0_RDP_BIT];
      wrp_on        = st.ob0[OB0_WRP_BIT];
      ext_clock     = st.ob1[OB1_STARTUP_LSB+1];
      range_field   = st.ob0[OB0_RANGE_LSB +: 3];
      boot_code     = st.ob0[OB0_BOOT_LSB +: 2];
      status_word    = 8'h00;
      status_word[2] = (st.phase == OBC_IDLE);
      status_word[1] = st.pm;
      status_word[0] = st.latched;

      // pulses fall by default, read data returns to zero
      next_st            = st;
      // pin chain: only an agreeing pair of late flops moves the level
      next_st.pm_sync    = {st.pm_sync[1:0], prog_mode_i};
      if (pm_agree) begin
         next_st.pm = st.pm_sync[1];
      end
      next_st.nv_wr0     = 1'b0;
      next_st.nv_wr1     = 1'b0;
      next_st.refused    = 1'b0;
      next_st.mass_erase = 1'b0;
      next_st.rdata      = 8'h00;
      // capture once after reset release; the copy stays put until next reset
      if (!st.latched) begin
         next_st.ob0     = nv_ob0_i;
         next_st.ob1     = nv_ob1_i;
         next_st.latched = 1'b1;
      end
      // decode from the held copy only, so a write-back never disturbs running clocks
      if (st.ob0[OB0_WAKE_BIT]) begin
         next_st.wake_vlp = 1'b0;
      end else begin
         next_st.wake_vlp = 1'b1;
      end
      next_st.range_valid = ext_clock;
      if (ext_clock) begin
         next_st.range = range_field;
      end else begin
         next_st.range = RANGE_LOW_POWER;
      end
      case (boot_code)
         2'h0: begin
            next_st.boot_bytes = BOOT_SIZE_0;
         end
         2'h1: begin
            next_st.boot_bytes = BOOT_SIZE_1;
         end
         2'h2: begin
            next_st.boot_bytes = BOOT_SIZE_2;
         end
         default: begin
            next_st.boot_bytes = BOOT_SIZE_3;
         end
      endcase
      if (rdp_on || wrp_on) begin
         next_st.flash_wr_ok = 1'b0;
      end else begin
         next_st.flash_wr_ok = 1'b1;
      end
      if (rdp_on) begin
         next_st.code_rd_ok = 1'b0;
      end else begin
         next_st.code_rd_ok = 1'b1;
      end

      // register port; option cells are only visible in programming mode
      if (rd_i) begin
         case (addr_i)
            ADDR_OB0: begin
               if (st.pm) begin
                  next_st.rdata = nv_ob0_i;
               end
            end
            ADDR_OB1: begin
               if (st.pm) begin
                  next_st.rdata = nv_ob1_i;
               end
            end
            ADDR_STATUS: begin
               next_st.rdata = status_word;
            end
            default: begin
               next_st.rdata = 8'h00;
            end
         endcase
      end

      // command sequencer; writes that arrive during an erase are dropped on purpose
      case (st.phase)
         OBC_IDLE: begin
            if (wr_i) begin
               if (!st.pm) begin
                  next_st.refused = 1'b1;
               end else if (wrp_on) begin
                  // write protection is final: nothing erases or programs past it
                  next_st.refused = 1'b1;
               end else if (ob_addr) begin
                  next_st.nv_wdata = wdata_i;
                  if (addr_i == ADDR_OB0) begin
                     next_st.nv_wr0 = 1'b1;
                  end else begin
                     next_st.nv_wr1 = 1'b1;
                  end
               end else if (cmd_mem_erase) begin
                  next_st.mass_erase = 1'b1;
               end else if (cmd_opt_erase) begin
                  if (rdp_on) begin
                     next_st.mass_erase = 1'b1;
                     next_st.phase      = OBC_MASS_ERASE;
                  end else begin
                     next_st.phase = OBC_OPT_ERASE;
                  end
               end else begin
                  next_st.refused = 1'b1;
               end
            end
         end
         OBC_MASS_ERASE: begin
            // option bytes stay intact until the whole array reports erased
            if (mass_erase_done_i) begin
               next_st.phase = OBC_OPT_ERASE;
            end
         end
         OBC_OPT_ERASE: begin
            next_st.nv_wdata = OB_ERASED;
            next_st.nv_wr0   = 1'b1;
            next_st.nv_wr1   = 1'b1;
            next_st.phase    = OBC_IDLE;
         end
         default: begin
            next_st.phase = OBC_IDLE;
         end
      endcase
   end

   // reset loads the default image; derived decode resets low, then shows the default image for one edge before the latched copy
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         st.pm_sync     <= 3'h0;
         st.pm          <= 1'b0;
         st.latched     <= 1'b0;
         st.ob0         <= OB0_DEFAULT;
         st.ob1         <= OB1_DEFAULT;
         st.phase       <= OBC_IDLE;
         st.rdata       <= 8'h00;
         st.nv_wdata    <= 8'h00;
         st.nv_wr0      <= 1'b0;
         st.nv_wr1      <= 1'b0;
         st.mass_erase  <= 1'b0;
         st.refused     <= 1'b0;
         st.wake_vlp    <= 1'b0;
         st.range       <= 3'h0;
         st.range_valid <= 1'b0;
         st.boot_bytes  <= 13'h0000;
         st.flash_wr_ok <= 1'b0;
         st.code_rd_ok  <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   assign rdata_o                = st.rdata;
   assign nv_wdata_o             = st.nv_wdata;
   assign nv_wr_ob0_o            = st.nv_wr0;
   assign nv_wr_ob1_o            = st.nv_wr1;
   assign mass_erase_o           = st.mass_erase;
   assign wakeup_clock_select_o  = st.ob0[OB0_WAKE_BIT];
   assign wake_src_vlp_o         = st.wake_vlp;
   assign osc_range_a_o          = st.range;
   assign osc_range_valid_o      = st.range_valid;
   assign startup_clock_select_o = st.ob1[OB1_STARTUP_LSB +: 2];
   assign boot_block_size_o      = st.ob0[OB0_BOOT_LSB +: 2];
   assign boot_block_bytes_o     = st.boot_bytes;
   assign readout_protect_o      = st.ob0[OB0_RDP_BIT];
   assign write_protect_o        = st.ob0[OB0_WRP_BIT];
   assign flash_write_allow_o    = st.flash_wr_ok;
   assign code_read_allow_o      = st.code_rd_ok;
   assign refused_o              = st.refused;
endmodule

// ===== verif/obc_decode_monitor.sv
// checker for obc_decode port relations
// assumes binding onto obc_decode, single clock, sync reset
`timescale 1ns/1ps
module obc_decode_monitor
   import obc_pkg::*;
(
   input wire logic        sys_clk_i, rst_i, wr_i, wakeup_clock_select_o, wake_src_vlp_o, readout_protect_o,
   input wire logic        write_protect_o, flash_write_allow_o, code_read_allow_o, mass_erase_o, nv_wr_ob0_o,
   input wire logic        refused_o, nv_wr_ob1_o, mass_erase_done_i,
   input wire logic [1:0]  startup_clock_select_o, boot_block_size_o,
   input wire logic [2:0]  osc_range_a_o,
   input wire logic [12:0] boot_block_bytes_o
);
   logic [1:0] settle;
   logic       ok;
   // decoded levels only settle two edges after reset release
   always_ff @(posedge sys_clk_i) settle <= rst_i ? 2'h0 : (settle == 2'h3 ? settle : settle + 2'h1);
   assign ok = settle == 2'h3;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   a_wake_inverse: assert property (ok |-> wake_src_vlp_o == !$past(wakeup_clock_select_o))
      else $error("vlp source flag wrong");
   a_range_gate: assert property (ok && !startup_clock_select_o[1] |-> osc_range_a_o == 3'h0)
      else $error("range not masked");
   a_boot_bytes: assert property (ok |-> boot_block_bytes_o == (13'h0200 << boot_block_size_o))
      else $error("boot size wrong");
   a_write_allow: assert property (ok |-> flash_write_allow_o == !(readout_protect_o || write_protect_o))
      else $error("write allow wrong");
   a_read_allow: assert property (ok |-> code_read_allow_o == !readout_protect_o)
      else $error("read allow wrong");
   a_decode_hold: assert property (ok && $past(ok) |-> $stable({wakeup_clock_select_o, osc_range_a_o,
      startup_clock_select_o, boot_block_size_o, readout_protect_o, write_protect_o})) else $error("decode moved");
   a_wp_refuse: assert property (ok && wr_i && write_protect_o |=> refused_o && !nv_wr_ob0_o && !mass_erase_o)
      else $error("write not refused");
   a_erase_first: assert property (nv_wr_ob0_o && nv_wr_ob1_o && readout_protect_o |-> $past(mass_erase_done_i, 2))
      else $error("option write before erase");
   c_erase: cover property (mass_erase_o);
   c_refuse: cover property (refused_o);
   c_nv_write: cover property (nv_wr_ob0_o);
endmodule
bind obc_decode obc_decode_monitor obc_decode_monitor_i (.*);

// ===== verif/obc_nv_model.sv
// far-side model: nonvolatile option cells and program-memory eraser
// assumes the bench preloads the cells through preload_i; erase answers slowly on purpose
`timescale 1ns/1ps
module obc_nv_model #(
   parameter int ERASE_CYC = 12
) (
   input  wire logic       sys_clk_i,
   input  wire logic       preload_i,
   input  wire logic [7:0] preload_ob0_i,
   input  wire logic [7:0] preload_ob1_i,
   input  wire logic [7:0] nv_wdata_i,
   input  wire logic       nv_wr_ob0_i,
   input  wire logic       nv_wr_ob1_i,
   input  wire logic       mass_erase_i,
   output logic      [7:0] ob0_o,
   output logic      [7:0] ob1_o,
   output logic            mass_erase_done_o
);
   int left = 0;
   initial mass_erase_done_o = 1'b0;
   // cells change only on bench preload or on decoder command, from a request accepted in programming mode only
   always @(posedge sys_clk_i) begin
      mass_erase_done_o <= left == 1;
      if (mass_erase_i) left <= ERASE_CYC;
      else if (left > 0) left <= left - 1;
      if (preload_i) begin
         ob0_o <= preload_ob0_i;
         ob1_o <= preload_ob1_i;
      end else begin
         if (nv_wr_ob0_i) ob0_o <= nv_wdata_i;
         if (nv_wr_ob1_i) ob1_o <= nv_wdata_i;
      end
   end
endmodule

// ===== verif/tb_obc_decode.sv
// directed testbench for obc_decode over its command port
// assumes obc_nv_model holds the option cells and eraser
`timescale 1ns/1ps
module tb_obc_decode;
   import obc_pkg::*;
   logic        sys_clk_i = 1'b0, rst_i = 1'b1, prog_mode_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
   logic [1:0]  addr_i = 2'h0, startup_clock_select_o, boot_block_size_o;
   logic [7:0]  wdata_i = 8'h00, rdata_o, nv_wdata_o, nv_ob0_i, nv_ob1_i, b1;
   logic        nv_wr_ob0_o, nv_wr_ob1_o, mass_erase_o, mass_erase_done_i, wakeup_clock_select_o, wake_src_vlp_o;
   logic        osc_range_valid_o, readout_protect_o, write_protect_o, flash_write_allow_o, code_read_allow_o;
   logic        refused_o, preload = 1'b0;
   logic [7:0]  pre_ob0 = 8'h00, pre_ob1 = 8'h00;
   logic [2:0]  osc_range_a_o;
   logic [12:0] boot_block_bytes_o;
   logic [7:0]  cfg [4] = '{8'h40, 8'h95, 8'hAA, 8'hBF};
   int          miscompares = 0, total_checks = 0, cycles = 0, n;
   initial forever #20 sys_clk_i = ~sys_clk_i;
   obc_decode obc_decode_i (.*);
   obc_nv_model obc_nv_model_i (.sys_clk_i(sys_clk_i), .preload_i(preload), .preload_ob0_i(pre_ob0),
      .preload_ob1_i(pre_ob1), .nv_wdata_i(nv_wdata_o), .nv_wr_ob0_i(nv_wr_ob0_o),
      .nv_wr_ob1_i(nv_wr_ob1_o), .mass_erase_i(mass_erase_o), .ob0_o(nv_ob0_i), .ob1_o(nv_ob1_i),
      .mass_erase_done_o(mass_erase_done_i));
   task automatic give_verdict;
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [12:0] got, input logic [12:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic restart(input logic [7:0] b0, input logic [7:0] bb);
      @(posedge sys_clk_i);
      rst_i   <= 1'b1;
      preload <= 1'b1;
      pre_ob0 <= b0;
      pre_ob1 <= bb;
      @(posedge sys_clk_i);
      preload <= 1'b0;
      repeat (7) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      // prog mode synchroniser needs four edges
      repeat (5) @(posedge sys_clk_i);
      #1;
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge sys_clk_i);
      wr_i <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [1:0] a);
      @(posedge sys_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge sys_clk_i);
      rd_i <= 1'b0;
      #1;
   endtask
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 2000) begin
         miscompares++;
         give_verdict;
      end
   end
   initial begin
      for (int i = 0; i < 4; i++) begin
         b1 = {~i[1:0], 6'h3F};
         restart(cfg[i], b1);
         chk(wakeup_clock_select_o, cfg[i][7]);
         chk({wake_src_vlp_o, osc_range_valid_o}, {!cfg[i][7], b1[7]});
         chk(boot_block_size_o, cfg[i][3:2]);
         chk(startup_clock_select_o, b1[7:6]);
         chk(osc_range_a_o, b1[7] ? cfg[i][6:4] : 3'h0);
         chk(boot_block_bytes_o, 13'h0200 << cfg[i][3:2]);
         chk({readout_protect_o, code_read_allow_o}, {cfg[i][1], !cfg[i][1]});
         chk({write_protect_o, flash_write_allow_o}, {cfg[i][0], cfg[i][1:0] == 2'h0});
         rd(ADDR_OB0);
         chk(rdata_o, 8'h00);
         wr(ADDR_OB0, 8'h00);
         chk({refused_o, nv_wr_ob0_o}, 2'h2);
      end
      @(posedge sys_clk_i);
      prog_mode_i <= 1'b1;
      restart(8'h40, 8'h3F);
      wr(ADDR_OB0, 8'h95);
      chk({refused_o, nv_wr_ob0_o, nv_wdata_o}, {2'h1, 8'h95});
      rd(ADDR_OB0);
      chk({rdata_o, write_protect_o}, {8'h95, 1'b0});
      rd(ADDR_OB1);
      chk(rdata_o, 8'h3F);
      wr(ADDR_CMD, CMD_ERASE_MEM);
      chk({refused_o, mass_erase_o}, 2'h1);
      wr(ADDR_CMD, 8'h00);
      chk(refused_o, 1'b1);
      rd(ADDR_STATUS);
      chk(rdata_o, 8'h07);
      restart(8'h95, 8'h3F);
      wr(ADDR_OB1, 8'h3F);
      chk({refused_o, nv_wr_ob1_o, write_protect_o}, 3'h5);
      wr(ADDR_CMD, CMD_ERASE_OPT);
      chk({refused_o, mass_erase_o}, 2'h2);
      restart(8'hAA, 8'h3F);
      wr(ADDR_CMD, CMD_ERASE_OPT);
      chk({mass_erase_o, nv_wr_ob0_o}, 2'h2);
      n = 0;
      while (nv_wr_ob0_o !== 1'b1 && n < 60) begin
         @(posedge sys_clk_i);
         #1;
         n++;
      end
      // the slow eraser takes twelve edges, so the option write must come later
      chk(n >= 12 && n < 60, 1'b1);
      chk({nv_wr_ob1_o, nv_wdata_o}, {1'b1, OB_ERASED});
      give_verdict;
   end
endmodule
